// File: logic/rim_top.sv
// Terminal interrupt manager: enable, pending, output enable, log word and request pin
`timescale 1ns/1ps
// How it works
// - With hardware match enable set, counter equal to utility value raises match event.
// - Terminal events with enable bit zero are ignored completely.
// - Disabled events are never remembered; enabling later raises nothing.
// - Enabled events OR into pending, keeping earlier unserviced bits.
// - Any terminal pending bit set by a message sets summary flag bit 2.
// - Every enabled terminal event writes a log identification word.
// - Request for output-enabled events is raised at message completion.
// - Reading terminal pending returns value then clears it to zero.
// - Active-low request is OR of the completion request latch and output-enabled hardware pending bits, except summary flag bit 2.
// - Events without output enable only update pending, summary flag bit 2 and log, polled.
// - Suppress option withholds request for illegal or busy commands.
// - Logged identification word mirrors terminal pending bit pattern.
// - Pending bit 9 reads zero; log bit 9 may report busy at event.
// - Terminal busy alone never makes an event, pending bit or log entry.
// - Bit n means the same event in enable, pending, output enable.
module rim_top
   import rim_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [7:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata,
   input wire logic [15:0] event_vec,
   input wire logic event_valid,
   input wire logic msg_done,
   input wire logic msg_illegal,
   input wire logic msg_busy,
   input wire logic terminal_busy,
   input wire logic [15:0] tt_count,
   output logic [15:0] log_word,
   output logic log_write,
   output logic irq_n
);
   typedef struct packed {
      logic [15:0] pending;
      logic [15:0] enable;
      logic [15:0] out_enable;
      logic [15:0] hw_pending;
      logic [15:0] hw_enable;
      logic [15:0] hw_out_enable;
      logic [15:0] tt_utility;
      logic [15:0] ext_config;
      logic [15:0] msg_acc;
      logic msg_suppress;
      logic rt_req;
      logic [15:0] rdata;
      logic [15:0] log_word;
      logic log_write;
   } rim_state_t;

   rim_state_t st;
   rim_state_t next_st;
   logic eq_level;
   logic tt_match;
   logic [15:0] ev_ok;

   assign eq_level = (tt_count == st.tt_utility);
   // Single pulse on first equality
   rim_edge u_match (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .level(eq_level),
      .rise(tt_match)
   );

   // Gate with enable at event time only
   assign ev_ok = event_valid ? (event_vec & st.enable & RIM_PENDING_MASK) : RIM_RESET_WORD;

   always_comb begin
      next_st = st;
      next_st.log_write = 1'b0;
      if (wr) begin
         case (addr)
            RIM_ADDR_ENABLE: next_st.enable = wdata;
            RIM_ADDR_OUT_ENABLE: next_st.out_enable = wdata;
            RIM_ADDR_HW_ENABLE: next_st.hw_enable = wdata;
            RIM_ADDR_HW_OUT_ENABLE: next_st.hw_out_enable = wdata;
            RIM_ADDR_TT_UTILITY: next_st.tt_utility = wdata;
            RIM_ADDR_EXT_CONFIG: next_st.ext_config = wdata;
            RIM_ADDR_HW_PENDING: next_st.hw_pending = st.hw_pending & ~wdata & RIM_HW_PENDING_MASK;
            default: next_st.ext_config = st.ext_config;
         endcase
      end
      next_st.rdata = RIM_RESET_WORD;
      if (rd) begin
         case (addr)
            RIM_ADDR_PENDING: begin
               next_st.rdata = st.pending & RIM_PENDING_MASK;
               next_st.pending = RIM_RESET_WORD;
            end
            RIM_ADDR_ENABLE: next_st.rdata = st.enable;
            RIM_ADDR_OUT_ENABLE: next_st.rdata = st.out_enable;
            RIM_ADDR_HW_PENDING: next_st.rdata = st.hw_pending;
            RIM_ADDR_HW_ENABLE: next_st.rdata = st.hw_enable;
            RIM_ADDR_HW_OUT_ENABLE: next_st.rdata = st.hw_out_enable;
            RIM_ADDR_TT_COUNT: next_st.rdata = tt_count;
            RIM_ADDR_TT_UTILITY: next_st.rdata = st.tt_utility;
            RIM_ADDR_EXT_CONFIG: next_st.rdata = st.ext_config;
            default: next_st.rdata = RIM_RESET_WORD;
         endcase
      end
      // Hardware match event, set wins over clear
      if (tt_match && st.hw_enable[RIM_BIT_TT_MATCH]) begin
         next_st.hw_pending[RIM_BIT_TT_MATCH] = 1'b1;
      end
      if (ev_ok != RIM_RESET_WORD) begin
         next_st.pending = next_st.pending | ev_ok;
         next_st.hw_pending[RIM_BIT_SUMMARY] = 1'b1;
         next_st.log_write = 1'b1;
         next_st.log_word = next_st.pending & RIM_PENDING_MASK;
         if (st.ext_config[RIM_BIT_LOG_BUSY]) begin
            next_st.log_word[RIM_BIT_BUSY_AT_EVENT] = terminal_busy;
         end
         next_st.msg_acc = st.msg_acc | ev_ok;
      end
      // Read clear first, so a completion in the same cycle wins
      if (rd && addr == RIM_ADDR_PENDING) begin
         next_st.rt_req = 1'b0;
      end
      if (msg_done) begin
         // Raise request at completion only
         if (((st.msg_acc | ev_ok) & st.out_enable) != RIM_RESET_WORD &&
             !(st.ext_config[RIM_BIT_SUPPRESS] && (msg_illegal || msg_busy))) begin
            next_st.rt_req = 1'b1;
         end
         next_st.msg_acc = RIM_RESET_WORD;
      end
      if (st.out_enable == RIM_RESET_WORD) begin
         next_st.rt_req = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st <= '0;
      end else if (ce) begin
         st <= next_st;
      end
   end

   assign rdata = st.rdata;
   assign log_word = st.log_word;
   assign log_write = st.log_write;
   // Shared request pin over both sets
   assign irq_n = ~(st.rt_req | (|(st.hw_pending & st.hw_out_enable & RIM_HW_PENDING_MASK &
                    ~(16'h0001 << RIM_BIT_SUMMARY))));

   property p_disabled_ignored;
      @(posedge clk) disable iff (rst)
      (ce && event_valid && ((event_vec & st.enable) == 16'h0000) && !rd) |=> !log_write;
   endproperty
   a_disabled_ignored: assert property (p_disabled_ignored) else $error("disabled event logged");

   property p_or_keep;
      @(posedge clk) disable iff (rst)
      (ce && !(rd && addr == RIM_ADDR_PENDING)) |=> ((st.pending & $past(st.pending)) == $past(st.pending));
   endproperty
   a_or_keep: assert property (p_or_keep) else $error("pending bit lost");

   property p_summary;
      @(posedge clk) disable iff (rst)
      (ce && ev_ok != 16'h0000) |=> st.hw_pending[2];
   endproperty
   a_summary: assert property (p_summary) else $error("summary flag not set");

   property p_log;
      @(posedge clk) disable iff (rst)
      (ce && ev_ok != 16'h0000) |=> log_write && ((log_word & 16'hFDFF) == (st.pending & 16'hFDFF));
   endproperty
   a_log: assert property (p_log) else $error("log word missing or wrong");

   property p_clear_on_read;
      @(posedge clk) disable iff (rst)
      (ce && rd && addr == RIM_ADDR_PENDING && ev_ok == 16'h0000) |=> st.pending == 16'h0000;
   endproperty
   a_clear_on_read: assert property (p_clear_on_read) else $error("pending not cleared");

   property p_bit9;
      @(posedge clk) disable iff (rst)
      ce |=> !st.pending[9];
   endproperty
   a_bit9: assert property (p_bit9) else $error("pending bit 9 set");

   property p_no_early_irq;
      @(posedge clk) disable iff (rst)
      (ce && !msg_done && !st.rt_req && st.hw_out_enable == 16'h0000 && !wr) |=> irq_n;
   endproperty
   a_no_early_irq: assert property (p_no_early_irq) else $error("request before completion");

   property p_suppress;
      @(posedge clk) disable iff (rst)
      (ce && msg_done && st.ext_config[0] && msg_illegal && !st.rt_req && st.hw_out_enable == 16'h0000 && !wr)
         |=> irq_n;
   endproperty
   a_suppress: assert property (p_suppress) else $error("request not suppressed");

   property p_match_once;
      @(posedge clk) disable iff (rst)
      (ce && tt_match) |=> !tt_match;
   endproperty
   a_match_once: assert property (p_match_once) else $error("match fired twice");

   property p_match_pending;
      @(posedge clk) disable iff (rst)
      (ce && tt_match && st.hw_enable[0]) |=> st.hw_pending[0];
   endproperty
   a_match_pending: assert property (p_match_pending) else $error("match not latched");

   property p_match_only;
      @(posedge clk) disable iff (rst)
      (ce && !(tt_match && st.hw_enable[0])) |=> !$rose(st.hw_pending[0]);
   endproperty
   a_match_only: assert property (p_match_only) else $error("match latched without event");

   property p_no_event_no_log;
      @(posedge clk) disable iff (rst)
      (ce && ev_ok == 16'h0000) |=> !log_write;
   endproperty
   a_no_event_no_log: assert property (p_no_event_no_log) else $error("log written without event");

   property p_pending_source;
      @(posedge clk) disable iff (rst)
      ce |=> ((st.pending & ~$past(st.pending) & ~$past(ev_ok)) == 16'h0000);
   endproperty
   a_pending_source: assert property (p_pending_source) else $error("pending bit without event");

   property p_disabled_kept;
      @(posedge clk) disable iff (rst)
      (ce && event_valid && ((event_vec & st.enable) == 16'h0000) && !(rd && addr == RIM_ADDR_PENDING))
         |=> st.pending == $past(st.pending);
   endproperty
   a_disabled_kept: assert property (p_disabled_kept) else $error("disabled event changed pending");

   property p_summary_keep;
      @(posedge clk) disable iff (rst)
      (ce && st.hw_pending[2] && !(wr && addr == RIM_ADDR_HW_PENDING)) |=> st.hw_pending[2];
   endproperty
   a_summary_keep: assert property (p_summary_keep) else $error("summary flag lost");

   property p_summary_source;
      @(posedge clk) disable iff (rst)
      (ce && ev_ok == 16'h0000) |=> !$rose(st.hw_pending[2]);
   endproperty
   a_summary_source: assert property (p_summary_source) else $error("summary flag without event");

   property p_irq_at_done;
      @(posedge clk) disable iff (rst)
      (ce && msg_done && ((st.msg_acc | ev_ok) & st.out_enable) != 16'h0000 && !st.ext_config[0]) |=> !irq_n;
   endproperty
   a_irq_at_done: assert property (p_irq_at_done) else $error("no request at completion");

   property p_irq_hold;
      @(posedge clk) disable iff (rst)
      (ce && st.rt_req && st.out_enable != 16'h0000 && !(rd && addr == RIM_ADDR_PENDING)) |=> !irq_n;
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("request dropped early");

   property p_irq_clear;
      @(posedge clk) disable iff (rst)
      (ce && rd && addr == RIM_ADDR_PENDING && !msg_done && !wr && st.hw_out_enable == 16'h0000) |=> irq_n;
   endproperty
   a_irq_clear: assert property (p_irq_clear) else $error("request kept after read");

   property p_hw_irq;
      @(posedge clk) disable iff (rst)
      (st.hw_pending[0] && st.hw_out_enable[0]) |-> !irq_n;
   endproperty
   a_hw_irq: assert property (p_hw_irq) else $error("hardware request missing");

   property p_low_priority;
      @(posedge clk) disable iff (rst)
      (ce && msg_done && ((st.msg_acc | ev_ok) & st.out_enable) == 16'h0000 && !st.rt_req &&
       st.hw_out_enable == 16'h0000 && !wr) |=> irq_n;
   endproperty
   a_low_priority: assert property (p_low_priority) else $error("low priority event raised request");

   property p_busy_suppress;
      @(posedge clk) disable iff (rst)
      (ce && msg_done && st.ext_config[0] && msg_busy && !st.rt_req && st.hw_out_enable == 16'h0000 && !wr)
         |=> irq_n;
   endproperty
   a_busy_suppress: assert property (p_busy_suppress) else $error("request not suppressed for busy");

   property p_log_busy;
      @(posedge clk) disable iff (rst)
      (ce && ev_ok != 16'h0000 && st.ext_config[2]) |=> log_word[9] == $past(terminal_busy);
   endproperty
   a_log_busy: assert property (p_log_busy) else $error("busy flag wrong in log");

   property p_log_no_busy;
      @(posedge clk) disable iff (rst)
      (ce && ev_ok != 16'h0000 && !st.ext_config[2]) |=> !log_word[9];
   endproperty
   a_log_no_busy: assert property (p_log_no_busy) else $error("log bit 9 set without option");

   property p_read_value;
      @(posedge clk) disable iff (rst)
      (ce && rd && addr == RIM_ADDR_PENDING) |=> rdata == ($past(st.pending) & 16'hFDFF);
   endproperty
   a_read_value: assert property (p_read_value) else $error("pending read value wrong");
endmodule

// File: logic/rim_pkg.sv
// Package: register map, fields and reset values of the terminal interrupt manager
package rim_pkg;
   localparam logic [7:0] RIM_ADDR_HW_PENDING = 8'h06;
   localparam logic [7:0] RIM_ADDR_PENDING = 8'h09;
   localparam logic [7:0] RIM_ADDR_HW_ENABLE = 8'h0F;
   localparam logic [7:0] RIM_ADDR_ENABLE = 8'h12;
   localparam logic [7:0] RIM_ADDR_HW_OUT_ENABLE = 8'h13;
   localparam logic [7:0] RIM_ADDR_OUT_ENABLE = 8'h16;
   localparam logic [7:0] RIM_ADDR_TT_COUNT = 8'h49;
   localparam logic [7:0] RIM_ADDR_TT_UTILITY = 8'h4A;
   localparam logic [7:0] RIM_ADDR_EXT_CONFIG = 8'h4D;
   localparam int RIM_BIT_SUMMARY = 2;
   localparam int RIM_BIT_TT_MATCH = 0;
   localparam int RIM_BIT_SUPPRESS = 0;
   localparam int RIM_BIT_LOG_BUSY = 2;
   localparam int RIM_BIT_BUSY_AT_EVENT = 9;
   localparam logic [15:0] RIM_RESET_WORD = 16'h0000;
   localparam logic [15:0] RIM_PENDING_MASK = 16'hFDFF;
   localparam logic [15:0] RIM_HW_PENDING_MASK = 16'h0005;
endpackage

// File: logic/rim_edge.sv
// Rising-edge detector with clock enable
`timescale 1ns/1ps
module rim_edge (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic level,
   output logic rise
);
   logic prev;
   always_ff @(posedge clk) begin
      if (rst) begin
         // Counter and utility are both zero after reset
         prev <= 1'b1;
      end else if (ce) begin
         prev <= level;
      end
   end
   assign rise = ce & level & ~prev;
endmodule

// File: test/rim_host.sv
// Host processor model: register bus master and request servicing
`timescale 1ns/1ps
module rim_host (
   input wire logic clk,
   input wire logic [15:0] rdata,
   output logic [7:0] addr,
   output logic [15:0] wdata,
   output logic wr,
   output logic rd
);
   initial {addr, wdata, wr, rd} = '0;
   task automatic put(input logic [7:0] a, input logic [15:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic get(input logic [7:0] a, output logic [15:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      v = rdata;
   endtask
   // Summary flag first, then terminal pending
   task automatic service(output logic [15:0] hw, output logic [15:0] p);
      get(8'h06, hw);
      p = 16'h0000;
      if (hw[2]) get(8'h09, p);
   endtask
endmodule

// File: test/testbench.sv
// Testbench of the terminal interrupt manager
`timescale 1ns/1ps
`define CK(n, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
   $display("Error %s expected %h seen %h", n, e, g); end end
module testbench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr;
   logic [15:0] wdata, rdata, log_word, d, hw;
   logic [15:0] ev = 16'h0000, tt = 16'h0000;
   logic wr, rd, log_write, irq_n;
   logic evv = 1'b0, done = 1'b0, ill = 1'b0, mbusy = 1'b0, tbusy = 1'b0, ce = 1'b1;
   int mismatches = 0;
   int total_checks = 0;
   initial begin
      forever #20 clk = ~clk;
   end
   rim_host host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
   rim_top dut (.clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .event_vec(ev), .event_valid(evv), .msg_done(done), .msg_illegal(ill),
      .msg_busy(mbusy), .terminal_busy(tbusy), .tt_count(tt), .log_word(log_word),
      .log_write(log_write), .irq_n(irq_n));
   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic event_in(input logic [15:0] v, input logic lw, input logic [15:0] w);
      @(posedge clk);
      ev <= v;
      evv <= 1'b1;
      @(posedge clk);
      evv <= 1'b0;
      @(negedge clk);
      `CK("log_write", lw, log_write)
      if (lw) `CK("log_word", w, log_word)
   endtask
   task automatic msg_end(input logic i, input logic b, input logic irq_exp);
      @(posedge clk);
      done <= 1'b1;
      ill <= i;
      mbusy <= b;
      @(posedge clk);
      done <= 1'b0;
      @(negedge clk);
      `CK("irq_n", irq_exp, irq_n)
   endtask
   task automatic t_disabled;
      host.get(8'h7F, d);
      `CK("unmapped", 16'h0000, d)
      host.put(8'h16, 16'h0008);
      event_in(16'h0008, 1'b0, 16'h0000);
      @(posedge clk) tbusy <= 1'b1;
      event_in(16'h0000, 1'b0, 16'h0000);
      @(posedge clk) tbusy <= 1'b0;
      host.put(8'h12, 16'h00FF);
      ce <= 1'b0;
      event_in(16'h0008, 1'b0, 16'h0000);
      @(posedge clk) ce <= 1'b1;
      host.get(8'h09, d);
      `CK("pending", 16'h0000, d)
      `CK("irq_n", 1'b1, irq_n)
   endtask
   task automatic t_enabled;
      event_in(16'h0008, 1'b1, 16'h0008);
      event_in(16'h0002, 1'b1, 16'h000A);
      `CK("irq_n", 1'b1, irq_n)
      msg_end(1'b0, 1'b0, 1'b0);
      host.service(hw, d);
      `CK("summary", 16'h0004, hw & 16'h0004)
      `CK("pending", 16'h000A, d)
      `CK("irq_n", 1'b1, irq_n)
      event_in(16'h0002, 1'b1, 16'h0002);
      msg_end(1'b0, 1'b0, 1'b1);
      host.get(8'h09, d);
      `CK("polled", 16'h0002, d)
   endtask
   task automatic t_suppress;
      host.put(8'h4D, 16'h0001);
      event_in(16'h0008, 1'b1, 16'h0008);
      msg_end(1'b1, 1'b0, 1'b1);
      event_in(16'h0008, 1'b1, 16'h0008);
      msg_end(1'b0, 1'b1, 1'b1);
      event_in(16'h0008, 1'b1, 16'h0008);
      msg_end(1'b0, 1'b0, 1'b0);
      host.get(8'h09, d);
      `CK("pending", 16'h0008, d)
      host.put(8'h4D, 16'h0004);
      @(posedge clk) tbusy <= 1'b1;
      event_in(16'h0208, 1'b1, 16'h0208);
      @(posedge clk) tbusy <= 1'b0;
      host.put(8'h4D, 16'h0000);
      event_in(16'h0001, 1'b1, 16'h0009);
      host.get(8'h09, d);
      `CK("pending", 16'h0009, d)
   endtask
   task automatic t_match;
      host.put(8'h06, 16'h0005);
      host.put(8'h4A, 16'h1234);
      host.put(8'h0F, 16'h0001);
      host.put(8'h13, 16'h0001);
      tt <= 16'h1234;
      host.get(8'h06, d);
      `CK("match", 16'h0001, d)
      `CK("irq_n", 1'b0, irq_n)
      host.put(8'h06, 16'h0001);
      host.get(8'h06, d);
      `CK("once", 16'h0000, d)
      `CK("irq_n", 1'b1, irq_n)
   endtask
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      t_disabled();
      t_enabled();
      t_suppress();
      t_match();
      end_sim();
   end
   initial begin
      repeat (5000) @(posedge clk);
      mismatches++;
      end_sim();
   end
endmodule
